// file: shared/smt_defs.vh
// Constants for the sync-reference monitor, time-stamp and overrange block.
// Overview of operation
// (RL1) Error correction follows frequency range and zone.
// (RL2) Decimation: sync event resets dividers, oscillator phase.
// (RL3) Bypass: fixed latency, sync restarts ramp pattern.
// (RL4) Pin function 0x00 makes pin 0 sync.
// (RL5) Mask bits choose which blocks a sync resets.
// (RL6) Source aligns sync edge to clock falling edge.
// (RL7) Sync level captured sixty picoseconds after edge.
// (RL8) Monitor spans minus sixty to plus 140 ps.
// (RL9) Exactly one of five window flags is raised; the code raises none when no adjacent tap pair differs.
// (RL10) Monitor status refreshes on each sync rising edge.
// (RL11) Edge-seen bit sticky until software clears it.
// (RL12) Status: zero, edge seen, any, flags five..one.
// (RL13) Bypass time-stamp registers sync low-to-high transition.
// (RL14) Marker replaces lane 2 LSB, parallel formats.
// (RL15) Marker after 8 cycles, data after 43.
// (RL16) Feature register value 0xC0 enables time-stamp.
// (RL17) Overrange flags clipping, configured by two registers.
// (RL18) Overrange latency never exceeds data latency.
// (RL19) Overrange may drive pin 0 per pin function.
// (RL20) Overrange may replace LSB of output data.
// (RL21) Combined indicator set when any window flag set.
// (RL22) Write one clears edge bit; flags read-only.
`ifndef SMT_DEFS_VH
`define SMT_DEFS_VH
`define SMT_AW 12
`define SMT_DW 14
`define SMT_OFS_OR_CFG_A 12'h10a
`define SMT_OFS_OR_CFG_B 12'h10b
`define SMT_OFS_OR_LSB 12'h116
`define SMT_OFS_FREQ_RANGE 12'h132
`define SMT_OFS_SYNC_MON 12'h140
`define SMT_OFS_PIN_FUNC 12'h146
`define SMT_OFS_FEATURE 12'h162
`define SMT_OFS_NYQ_ZONE 12'h16b
`define SMT_RST_OR_CFG_A 8'h01
`define SMT_RST_OR_CFG_B 8'h00
`define SMT_RST_OR_LSB 8'h00
`define SMT_RST_FREQ_RANGE 8'h00
`define SMT_RST_PIN_FUNC 8'h02
`define SMT_RST_FEATURE 8'h00
`define SMT_RST_NYQ_ZONE 8'h00
`define SMT_PINFN_SYNC 8'h00
`define SMT_PINFN_OVR 8'h01
`define SMT_TS_EN_BITS 2'b11
`define SMT_TS_EN_HI 7
`define SMT_TS_EN_LO 6
`define SMT_OR_EN_BIT 0
`define SMT_OR_LSB_BIT 0
`define SMT_MON_EDGE_BIT 6
`define SMT_MON_ANY_BIT 5
`define SMT_MASK_DIV 0
`define SMT_MASK_NCO 1
`define SMT_MASK_RAMP 2
`define SMT_TAPS 6
`define SMT_CAPTURE_DELAY_PS 60
`define SMT_WINDOW_START_PS 60
`define SMT_WINDOW_END_PS 140
`define SMT_DATA_LAT 43
`define SMT_MARK_LAT 8
`define SMT_MARK_LEAD (`SMT_DATA_LAT - `SMT_MARK_LAT)
`define SMT_CODE_MAX 14'h1fff
`define SMT_CODE_MIN 14'h2000
`endif

// file: src/smt_sync3.v
// Three-stage pin synchroniser with agreement filter.
`timescale 1ns/1ns
module smt_sync3 #(
  parameter W = 1
) (
  input wire clk_in,
  input wire rst_in,
  input wire [W-1:0] pin_in,
  output reg [W-1:0] level_out
);

  reg [W-1:0] s1_q;
  reg [W-1:0] s2_q;
  reg [W-1:0] s3_q;
  integer i;

  // Only the second stage reads the first; a bit changes once stages two and three agree.
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      s1_q <= {W{1'b0}};
      s2_q <= {W{1'b0}};
      s3_q <= {W{1'b0}};
      level_out <= {W{1'b0}};
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (i = 0; i < W; i = i + 1) begin
        if (s2_q[i] == s3_q[i]) begin
          level_out[i] <= s3_q[i];
        end
      end
    end
  end

endmodule // smt_sync3

// file: src/smt_sync_monitor.v
// Sync-reference capture, window monitor, time-stamp and overrange logic.
`timescale 1ns/1ns
`include "smt_defs.vh"
module smt_sync_monitor (
  input wire REF_CLK_IN,
  input wire RESET_IN,
  input wire [`SMT_AW-1:0] REG_ADDR_IN,
  input wire [7:0] REG_WDATA_IN,
  input wire REG_WR_IN,
  output reg [7:0] REG_RDATA_OUT,
  input wire GP_PIN_0_IN,
  output reg GP_PIN_0_OUT,
  output reg GP_PIN_0_OE_OUT,
  input wire [`SMT_TAPS-1:0] SYNC_TAPS_IN,
  input wire DECIM_MODE_IN,
  input wire [2:0] SYNC_MASK_IN,
  input wire [`SMT_DW-1:0] DATA_IN,
  output reg [`SMT_DW-1:0] DATA_OUT,
  output reg DIV_RESET_OUT,
  output reg NCO_PHASE_RESET_OUT,
  output reg RAMP_RESET_OUT,
  output reg [7:0] CORR_RANGE_OUT,
  output reg [7:0] CORR_ZONE_OUT
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation.

  wire [`SMT_TAPS:0] pins_raw;
  wire [`SMT_TAPS:0] pins_sync;
  wire sync_pin_level;
  wire [`SMT_TAPS-1:0] taps;

  assign pins_raw = {GP_PIN_0_IN, SYNC_TAPS_IN};

  // Pin and taps share one synchroniser so their alignment is preserved.
  smt_sync3 #(
    .W(`SMT_TAPS + 1)
  ) u_sync (
    .clk_in(REF_CLK_IN),
    .rst_in(RESET_IN),
    .pin_in(pins_raw),
    .level_out(pins_sync)
  );

  assign sync_pin_level = pins_sync[`SMT_TAPS]; // RL7
  assign taps = pins_sync[`SMT_TAPS-1:0];

  ////////////////////////////////////////////////////////////////////////////
  // Register file.

  reg [7:0] or_cfg_a_q;
  reg [7:0] or_cfg_b_q;
  reg [7:0] or_lsb_q;
  reg [7:0] freq_range_q;
  reg [7:0] pin_func_q;
  reg [7:0] feature_q;
  reg [7:0] nyq_zone_q;
  reg sync_edge_seen_q;
  reg sync_window_any_q;
  reg [4:0] window_flags_q;

  wire wr_or_a;
  wire wr_or_b;
  wire wr_or_lsb;
  wire wr_range;
  wire wr_mon;
  wire wr_pin;
  wire wr_feat;
  wire wr_nyq;

  assign wr_or_a = REG_WR_IN && (REG_ADDR_IN == `SMT_OFS_OR_CFG_A);
  assign wr_or_b = REG_WR_IN && (REG_ADDR_IN == `SMT_OFS_OR_CFG_B);
  assign wr_or_lsb = REG_WR_IN && (REG_ADDR_IN == `SMT_OFS_OR_LSB);
  assign wr_range = REG_WR_IN && (REG_ADDR_IN == `SMT_OFS_FREQ_RANGE);
  assign wr_mon = REG_WR_IN && (REG_ADDR_IN == `SMT_OFS_SYNC_MON);
  assign wr_pin = REG_WR_IN && (REG_ADDR_IN == `SMT_OFS_PIN_FUNC);
  assign wr_feat = REG_WR_IN && (REG_ADDR_IN == `SMT_OFS_FEATURE);
  assign wr_nyq = REG_WR_IN && (REG_ADDR_IN == `SMT_OFS_NYQ_ZONE);

  always @(posedge REF_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      or_cfg_a_q <= `SMT_RST_OR_CFG_A;
      or_cfg_b_q <= `SMT_RST_OR_CFG_B;
      or_lsb_q <= `SMT_RST_OR_LSB;
      freq_range_q <= `SMT_RST_FREQ_RANGE;
      pin_func_q <= `SMT_RST_PIN_FUNC;
      feature_q <= `SMT_RST_FEATURE;
      nyq_zone_q <= `SMT_RST_NYQ_ZONE; // RL1
    end else begin
      if (wr_or_a) begin
        or_cfg_a_q <= REG_WDATA_IN; // RL17
      end
      if (wr_or_b) begin
        or_cfg_b_q <= REG_WDATA_IN; // RL17
      end
      if (wr_or_lsb) begin
        or_lsb_q <= REG_WDATA_IN;
      end
      if (wr_range) begin
        freq_range_q <= REG_WDATA_IN;
      end
      if (wr_pin) begin
        pin_func_q <= REG_WDATA_IN;
      end
      if (wr_feat) begin
        feature_q <= REG_WDATA_IN;
      end
      if (wr_nyq) begin
        nyq_zone_q <= REG_WDATA_IN;
      end
    end
  end

  // The error-correction tuning follows the programmed range and zone.
  always @(posedge REF_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      CORR_RANGE_OUT <= `SMT_RST_FREQ_RANGE;
      CORR_ZONE_OUT <= `SMT_RST_NYQ_ZONE;
    end else begin
      CORR_RANGE_OUT <= freq_range_q; // RL1
      CORR_ZONE_OUT <= nyq_zone_q; // RL1
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sync-reference edge and block resets.

  reg sync_level_q;
  wire sync_sel;
  wire sync_level;
  wire sync_rise;
  wire decim_sync;
  wire bypass_sync;

  assign sync_sel = (pin_func_q == `SMT_PINFN_SYNC); // RL4
  assign sync_level = sync_sel & sync_pin_level;
  assign sync_rise = sync_level & ~sync_level_q;
  // A sync event reaches only the blocks whose mask bit is set.
  assign decim_sync = sync_rise & DECIM_MODE_IN; // RL2
  assign bypass_sync = sync_rise & ~DECIM_MODE_IN; // RL3

  always @(posedge REF_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      sync_level_q <= 1'b0;
      DIV_RESET_OUT <= 1'b0;
      NCO_PHASE_RESET_OUT <= 1'b0;
      RAMP_RESET_OUT <= 1'b0;
    end else begin
      sync_level_q <= sync_level;
      DIV_RESET_OUT <= decim_sync & SYNC_MASK_IN[`SMT_MASK_DIV]; // RL2 RL5
      NCO_PHASE_RESET_OUT <= decim_sync & SYNC_MASK_IN[`SMT_MASK_NCO]; // RL2 RL5
      RAMP_RESET_OUT <= bypass_sync & SYNC_MASK_IN[`SMT_MASK_RAMP]; // RL3 RL5
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Window monitor.

  // Adjacent tap pairs bracket the five windows; the earliest transition wins
  // so that a slow edge straddling two windows still raises a single flag.
  wire lead_window_1;
  wire center_window_2;
  wire lag_window_3;
  wire lag_window_4;
  wire lag_window_5;
  wire [4:0] tap_diff;
  wire edge_clear;
  wire [7:0] mon_status;
  reg [4:0] window_pick;

  // Each window is a pair of neighbouring taps that disagree.
  assign lead_window_1 = taps[0] ^ taps[1]; // RL8
  assign center_window_2 = taps[1] ^ taps[2]; // RL8
  assign lag_window_3 = taps[2] ^ taps[3]; // RL8
  assign lag_window_4 = taps[3] ^ taps[4]; // RL8
  assign lag_window_5 = taps[4] ^ taps[5]; // RL8
  assign tap_diff = {lag_window_5, lag_window_4, lag_window_3, center_window_2, lead_window_1};
  assign edge_clear = wr_mon && REG_WDATA_IN[`SMT_MON_EDGE_BIT]; // RL22
  // Bit seven has no source behind it and always reads zero.
  assign mon_status = {1'b0, sync_edge_seen_q, sync_window_any_q, window_flags_q}; // RL12

  always @* begin
    window_pick = 5'h00;
    if (tap_diff[0]) begin
      window_pick = 5'h01; // RL9
    end else if (tap_diff[1]) begin
      window_pick = 5'h02;
    end else if (tap_diff[2]) begin
      window_pick = 5'h04;
    end else if (tap_diff[3]) begin
      window_pick = 5'h08;
    end else if (tap_diff[4]) begin
      window_pick = 5'h10;
    end
  end

  always @(posedge REF_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      window_flags_q <= 5'h00;
      sync_window_any_q <= 1'b0;
      sync_edge_seen_q <= 1'b0;
    end else begin
      if (sync_rise) begin
        window_flags_q <= window_pick; // RL10 RL22
        sync_window_any_q <= |window_pick; // RL21
      end
      // A new edge in the clearing cycle keeps the bit set.
      if (sync_rise) begin
        sync_edge_seen_q <= 1'b1; // RL11
      end else if (edge_clear) begin
        sync_edge_seen_q <= 1'b0; // RL22
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Overrange detection.

  reg [7:0] or_stretch_q;
  wire or_enable;
  wire code_at_limit;
  wire or_clip;
  wire overrange_now;

  // Only the two clip codes count, so a sample just inside the range flags only while a stretch runs.
  assign or_enable = or_cfg_a_q[`SMT_OR_EN_BIT]; // RL17
  assign code_at_limit = (DATA_IN == `SMT_CODE_MAX) || (DATA_IN == `SMT_CODE_MIN);
  assign or_clip = or_enable && code_at_limit; // RL17
  assign overrange_now = or_clip || (or_stretch_q != 8'h00);

  // The second register stretches a short clip so slow readers see it.
  always @(posedge REF_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      or_stretch_q <= 8'h00;
    end else if (or_clip) begin
      or_stretch_q <= or_cfg_b_q; // RL17
    end else if (or_stretch_q != 8'h00) begin
      or_stretch_q <= or_stretch_q - 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data and marker pipelines.

  // Overrange rides with its sample so its latency equals the data latency.
  reg [`SMT_DW:0] data_pipe [0:`SMT_DATA_LAT-2];
  reg [`SMT_MARK_LAT-2:0] mark_pipe_q;
  wire ts_bits_on;
  wire ts_enable;
  wire [`SMT_DW:0] data_tail;
  wire mark_tail;
  wire overrange_flag;
  reg output_lane_2;
  integer k;

  assign ts_bits_on = (feature_q[`SMT_TS_EN_HI:`SMT_TS_EN_LO] == `SMT_TS_EN_BITS); // RL16
  assign ts_enable = ts_bits_on & ~DECIM_MODE_IN; // RL14
  assign data_tail = data_pipe[`SMT_DATA_LAT-2];
  assign mark_tail = mark_pipe_q[`SMT_MARK_LAT-2];
  assign overrange_flag = data_tail[`SMT_DW]; // RL18

  always @(posedge REF_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      for (k = 0; k < `SMT_DATA_LAT - 1; k = k + 1) begin
        data_pipe[k] <= {(`SMT_DW + 1){1'b0}};
      end
      mark_pipe_q <= {(`SMT_MARK_LAT - 1){1'b0}};
    end else begin
      data_pipe[0] <= {overrange_now, DATA_IN}; // RL18 RL3
      for (k = 1; k < `SMT_DATA_LAT - 1; k = k + 1) begin
        data_pipe[k] <= data_pipe[k-1];
      end
      mark_pipe_q <= {mark_pipe_q[`SMT_MARK_LAT-3:0], sync_rise & ts_enable}; // RL13 RL15
    end
  end

  // The marker is not latency-matched; it wins the LSB over overrange.
  always @* begin
    output_lane_2 = data_tail[0];
    if (ts_enable) begin
      output_lane_2 = mark_tail; // RL14 RL15
    end else if (or_lsb_q[`SMT_OR_LSB_BIT]) begin
      output_lane_2 = overrange_flag; // RL20
    end
  end

  always @(posedge REF_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      DATA_OUT <= {`SMT_DW{1'b0}};
    end else begin
      DATA_OUT <= {data_tail[`SMT_DW-1:1], output_lane_2}; // RL14 RL20
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // General-purpose pin drive.

  wire pin_is_ovr;

  // The pin is driven only while it carries overrange; otherwise it stays an input.
  assign pin_is_ovr = (pin_func_q == `SMT_PINFN_OVR); // RL19

  always @(posedge REF_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      GP_PIN_0_OUT <= 1'b0;
      GP_PIN_0_OE_OUT <= 1'b0;
    end else begin
      GP_PIN_0_OE_OUT <= pin_is_ovr; // RL19
      GP_PIN_0_OUT <= pin_is_ovr & overrange_flag; // RL19 RL18
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path.

  reg [7:0] rd_mux;

  always @* begin
    case (REG_ADDR_IN)
      `SMT_OFS_OR_CFG_A: rd_mux = or_cfg_a_q;
      `SMT_OFS_OR_CFG_B: rd_mux = or_cfg_b_q;
      `SMT_OFS_OR_LSB: rd_mux = or_lsb_q;
      `SMT_OFS_FREQ_RANGE: rd_mux = freq_range_q;
      `SMT_OFS_SYNC_MON: rd_mux = mon_status; // RL12
      `SMT_OFS_PIN_FUNC: rd_mux = pin_func_q;
      `SMT_OFS_FEATURE: rd_mux = feature_q;
      `SMT_OFS_NYQ_ZONE: rd_mux = nyq_zone_q;
      default: rd_mux = 8'h00;
    endcase
  end

  always @(posedge REF_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      REG_RDATA_OUT <= 8'h00;
    end else begin
      REG_RDATA_OUT <= rd_mux;
    end
  end

endmodule // smt_sync_monitor

// file: tb/smt_sync_monitor_bench.sv
// Self-checking bench for the sync monitor block.
`timescale 1ns/1ns
`include "smt_defs.vh"
module smt_sync_monitor_bench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [11:0] addr = 12'h000;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic decim = 1'b1;
  logic or_req = 1'b0;
  logic [2:0] mask = 3'h7;
  logic [11:0] cnt = 12'h000;
  logic [13:0] din = 14'h0000;
  logic [7:0] rdata, corr_rng, corr_zone;
  logic [13:0] dout;
  logic gp_out, gp_oe, src_pin, div_rst, nco_rst, ramp;
  logic [5:0] taps;
  logic [15:0] n_div = 16'h0000;
  logic [15:0] n_nco = 16'h0000;
  int n_errors = 0;
  int total_checks = 0;
  int cyc = 0;
  int i, k, j;
  logic [11:0] ra [0:8] = '{12'h10a, 12'h10b, 12'h116, 12'h132, 12'h140, 12'h146, 12'h162, 12'h16b, 12'h100};
  logic [7:0] rv [0:8] = '{8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00, 8'h00};
  // The pin level is the block's drive while it is enabled, else the source's.
  wire gp_in = gp_oe ? gp_out : src_pin;
  ////////////////////////////////////////
  always #10 clk = ~clk;
  smt_sync_monitor i_smt_sync_monitor (.REF_CLK_IN(clk), .RESET_IN(rst), .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata),
    .REG_WR_IN(wr), .REG_RDATA_OUT(rdata), .GP_PIN_0_IN(gp_in), .GP_PIN_0_OUT(gp_out), .GP_PIN_0_OE_OUT(gp_oe),
    .SYNC_TAPS_IN(taps), .DECIM_MODE_IN(decim), .SYNC_MASK_IN(mask), .DATA_IN(din), .DATA_OUT(dout),
    .DIV_RESET_OUT(div_rst), .NCO_PHASE_RESET_OUT(nco_rst), .RAMP_RESET_OUT(ramp), .CORR_RANGE_OUT(corr_rng),
    .CORR_ZONE_OUT(corr_zone));
  smt_sync_source i_smt_sync_source (.clk_in(clk), .pin_out(src_pin), .taps_out(taps));
  // Even samples keep the output LSB free for the marker and the overrange bit.
  always @(negedge clk) begin
    cnt <= cnt + 12'h001;
    din <= or_req ? 14'h2000 : {1'b0, cnt, 1'b0};
  end
  always @(posedge clk) begin
    if (div_rst) n_div <= n_div + 16'h0001;
    if (nco_rst) n_nco <= n_nco + 16'h0001;
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_errors++;
      close_out();
    end
  end
  ////////////////////////////////////////
  task chk(input logic [15:0] got, input logic [15:0] exp);
    begin
      total_checks++;
      if (got !== exp) begin
        n_errors++;
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task wrr(input logic [11:0] a, input logic [7:0] d);
    begin
      @(negedge clk);
      addr = a;
      wdata = d;
      wr = 1'b1;
      @(negedge clk);
      wr = 1'b0;
    end
  endtask
  task rdc(input logic [11:0] a, input logic [7:0] e);
    begin
      @(negedge clk);
      addr = a;
      @(negedge clk);
      chk({8'h00, rdata}, {8'h00, e});
    end
  endtask
  task close_out;
    begin
      $display("checks=%0d errors=%0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
        $display("[ PASS ]");
      end else begin
        $display("[ FAIL ]");
      end
      $finish;
    end
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (5) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    for (i = 0; i < 9; i++) begin
      rdc(ra[i], rv[i]);
    end
    chk({8'h00, corr_zone}, 16'h0000);
    wrr(12'h100, 8'hff);
    rdc(12'h100, 8'h00);
    wrr(12'h132, 8'h5a);
    wrr(12'h16b, 8'h01);
    rdc(12'h132, 8'h5a);
    rdc(12'h16b, 8'h01);
    chk({8'h00, corr_rng}, 16'h005a);
    chk({8'h00, corr_zone}, 16'h0001);
    wrr(12'h146, 8'h00);
    for (k = 1; k < 6; k++) begin
      i_smt_sync_source.pulse(6'h3f << k);
      rdc(12'h140, 8'h60 | (8'h01 << (k - 1)));
    end
    chk(n_div, 16'h0005);
    mask = 3'b010;
    i_smt_sync_source.pulse(6'h38);
    chk(n_div, 16'h0005);
    chk(n_nco, 16'h0006);
    wrr(12'h140, 8'h40);
    rdc(12'h140, 8'h24);
    wrr(12'h140, 8'hbf);
    rdc(12'h140, 8'h24);
    wrr(12'h146, 8'h02);
    i_smt_sync_source.pulse(6'h3e);
    rdc(12'h140, 8'h24);
    decim = 1'b0;
    mask = 3'b100;
    wrr(12'h146, 8'h00);
    wrr(12'h162, 8'hc0);
    fork
      i_smt_sync_source.pulse(6'h38);
    join_none
    j = 0;
    while (ramp !== 1'b1 && j < 40) begin
      @(negedge clk);
      j++;
    end
    chk(ramp, 16'h1);
    repeat (6) @(negedge clk);
    chk(dout[0], 16'h0);
    @(negedge clk);
    chk(dout[0], 16'h1);
    repeat (20) @(negedge clk);
    wrr(12'h162, 8'h00);
    wrr(12'h116, 8'h01);
    wrr(12'h146, 8'h01);
    @(negedge clk);
    chk(gp_oe, 16'h1);
    or_req <= 1'b1;
    @(negedge clk);
    or_req <= 1'b0;
    repeat (42) @(negedge clk);
    chk(dout[0], 16'h0);
    @(negedge clk);
    chk(dout[0], 16'h1);
    chk(gp_out, 16'h1);
    close_out();
  end
endmodule // smt_sync_monitor_bench
bind smt_sync_monitor smt_mon_chk i_smt_mon_chk (.REF_CLK_IN(REF_CLK_IN), .RESET_IN(RESET_IN),
  .REG_ADDR_IN(REG_ADDR_IN), .REG_WDATA_IN(REG_WDATA_IN), .REG_WR_IN(REG_WR_IN), .REG_RDATA_OUT(REG_RDATA_OUT),
  .DECIM_MODE_IN(DECIM_MODE_IN), .SYNC_MASK_IN(SYNC_MASK_IN), .DATA_IN(DATA_IN), .DATA_OUT(DATA_OUT),
  .DIV_RESET_OUT(DIV_RESET_OUT), .NCO_PHASE_RESET_OUT(NCO_PHASE_RESET_OUT), .RAMP_RESET_OUT(RAMP_RESET_OUT),
  .CORR_RANGE_OUT(CORR_RANGE_OUT));

// file: tb/smt_sync_monitor_monitor.sv
// Port-level timing checker for the sync monitor block.
`timescale 1ns/1ns
`include "smt_defs.vh"
module smt_mon_chk (
  input wire REF_CLK_IN,
  input wire RESET_IN,
  input wire [`SMT_AW-1:0] REG_ADDR_IN,
  input wire [7:0] REG_WDATA_IN,
  input wire REG_WR_IN,
  input wire [7:0] REG_RDATA_OUT,
  input wire DECIM_MODE_IN,
  input wire [2:0] SYNC_MASK_IN,
  input wire [`SMT_DW-1:0] DATA_IN,
  input wire [`SMT_DW-1:0] DATA_OUT,
  input wire DIV_RESET_OUT,
  input wire NCO_PHASE_RESET_OUT,
  input wire RAMP_RESET_OUT,
  input wire [7:0] CORR_RANGE_OUT
);
  reg [5:0] lat_q;
  ////////////////////////////////////////
  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (RESET_IN);
  // The data check waits until the pipeline holds only samples taken after reset.
  always @(posedge REF_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      lat_q <= 6'h00;
    end else if (lat_q != 6'h2d) begin
      lat_q <= lat_q + 6'h01;
    end
  end
  ////////////////////////////////////////
  AST_DATA_LAT:
    assert property (lat_q == 6'h2d |-> DATA_OUT[13:1] == $past(DATA_IN[13:1], 43)) else $error("Data latency wrong.");
  AST_MON_B7:
    assert property ($past(REG_ADDR_IN) == 12'h140 |-> !REG_RDATA_OUT[7]) else $error("Monitor bit 7 set.");
  AST_MON_ANY:
    assert property ($past(REG_ADDR_IN) == 12'h140 |-> REG_RDATA_OUT[5] == |REG_RDATA_OUT[4:0])
    else $error("Combined window bit wrong.");
  AST_MON_ONE:
    assert property ($past(REG_ADDR_IN) == 12'h140 |-> $onehot0(REG_RDATA_OUT[4:0])) else $error("Several flags.");
  AST_DIV_PULSE:
    assert property (DIV_RESET_OUT |=> !DIV_RESET_OUT) else $error("Divider reset too long.");
  AST_DIV_MASK:
    assert property (DIV_RESET_OUT |-> $past(SYNC_MASK_IN[0]) && $past(DECIM_MODE_IN)) else $error("Divider reset unmasked.");
  AST_NCO_MASK:
    assert property (NCO_PHASE_RESET_OUT |-> $past(SYNC_MASK_IN[1]) && $past(DECIM_MODE_IN)) else $error("Phase reset unmasked.");
  AST_RAMP_MODE:
    assert property (RAMP_RESET_OUT |-> $past(SYNC_MASK_IN[2]) && !$past(DECIM_MODE_IN)) else $error("Ramp reset wrong.");
  AST_CORR_COPY:
    assert property (REG_WR_IN && REG_ADDR_IN == 12'h132 |-> ##2 CORR_RANGE_OUT == $past(REG_WDATA_IN, 2))
    else $error("Range copy wrong.");
endmodule // smt_mon_chk

// file: tb/smt_sync_source.sv
// External sync-reference source driving pin 0 and the window taps.
`timescale 1ns/1ns
module smt_sync_source (
  input wire clk_in,
  output reg pin_out,
  output reg [5:0] taps_out
);
  initial begin
    pin_out = 1'b0;
    taps_out = 6'h00;
  end
  // The rise is launched on the falling clock edge, which gives the widest capture margin.
  task pulse(input logic [5:0] t);
    begin
      @(negedge clk_in);
      pin_out = 1'b1;
      taps_out = t;
      repeat (8) @(negedge clk_in);
      pin_out = 1'b0;
      taps_out = 6'h00;
      // Long low time so that the next rise is filtered as a new edge.
      repeat (8) @(negedge clk_in);
    end
  endtask
endmodule // smt_sync_source
